// File: core/vsp_pkg.sv
package vsp_pkg;

  // Voltmeter program word layout
  localparam int PW_W          = 16;
  localparam int PW_ENCODE_BIT = 15;
  localparam int PW_RANGE_LSB  = 0;
  localparam int PW_FUNC_LSB   = 3;
  localparam int PW_PER_LSB    = 6;
  localparam int OCT_W         = 3;
  localparam int PER_W         = 2;

  typedef enum logic [2:0] {
    VSP_RNG_AUTO   = 3'h0, VSP_RNG_GAIN10 = 3'h1, VSP_RNG_0V1 = 3'h2,
    VSP_RNG_1V     = 3'h3, VSP_RNG_10V    = 3'h4, VSP_RNG_100V = 3'h5,
    VSP_RNG_1000V  = 3'h6, VSP_RNG_10MOHM = 3'h7
  } vsp_range_t;

  typedef enum logic [2:0] {
    VSP_FN_AC_NORMAL = 3'h0, VSP_FN_AC_FAST = 3'h1, VSP_FN_FREQ = 3'h2,
    VSP_FN_PERIOD    = 3'h3, VSP_FN_DC_VOLTS = 3'h4, VSP_FN_OHMS = 3'h5
  } vsp_func_t;

  typedef enum logic [1:0] {
    VSP_PER_1S = 2'h0, VSP_PER_100MS = 2'h1, VSP_PER_10MS = 2'h2
  } vsp_period_t;

  // Function digit of the result word
  typedef enum logic [3:0] {
    VSP_RF_PERIOD = 4'h0, VSP_RF_POS_DC = 4'h1, VSP_RF_NEG_DC = 4'h2,
    VSP_RF_KHZ    = 4'h3, VSP_RF_KOHM   = 4'h4, VSP_RF_MOHM   = 4'h5,
    VSP_RF_OVERLOAD = 4'h9, VSP_RF_AC_VOLTS = 4'hB
  } vsp_res_func_t;

  // Result word layout: range, function, six data digits
  localparam int RES_W         = 32;
  localparam int DIGIT_W       = 4;
  localparam int RES_RANGE_LSB = 28;
  localparam int RES_FUNC_LSB  = 24;
  localparam int RES_DATA_W    = 24;

  // Scanner
  localparam int          CHAN_W          = 10;
  localparam logic [9:0]  CHAN_MAX        = 10'h3E7;
  localparam int          SW_DELAY_LSB    = 0;
  localparam int          SW_FUNC_LSB     = 3;

  typedef enum logic [2:0] {
    VSP_SF_ACDC = 3'h0, VSP_SF_FREQ = 3'h1, VSP_SF_RES = 3'h2
  } vsp_scan_func_t;

  // Settling delays in microseconds, one entry per delay digit
  localparam int CLK_PERIOD_NS = 100;
  localparam int DLY_CNT_W     = 23;
  typedef int unsigned vsp_dly_arr_t [8];
  localparam vsp_dly_arr_t DLY_HV_US =
    '{15000, 17500, 22000, 27000, 42000, 62000, 145000, 500000};
  localparam vsp_dly_arr_t DLY_NORM_US =
    '{22000, 27000, 22000, 27000, 145000, 500000, 145000, 500000};

  // Least times round up to whole cycles
  function automatic vsp_dly_arr_t vsp_us_to_cyc(vsp_dly_arr_t us);
    vsp_dly_arr_t c;
    for (int i = 0; i < 8; i++) begin
      c[i] = (us[i] * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    end
    return c;
  endfunction

  // Character string: positions and codes
  localparam int         CHAR_IDX_W = 4;
  localparam logic [3:0] IDX_RANGE  = 4'h0;
  localparam logic [3:0] IDX_FUNC   = 4'h1;
  localparam logic [3:0] IDX_D1     = 4'h7;
  localparam logic [3:0] IDX_EXP_E  = 4'h8;
  localparam logic [3:0] IDX_EXP_SG = 4'h9;
  localparam logic [3:0] IDX_EXP_Z  = 4'hA;
  localparam logic [3:0] IDX_EXP_R  = 4'hB;
  localparam logic [3:0] IDX_FC_HI  = 4'hE;
  localparam logic [3:0] IDX_LAST   = 4'hF;
  localparam logic [7:0] CH_ZERO    = 8'h30;
  localparam logic [7:0] CH_ONE     = 8'h31;
  localparam logic [7:0] CH_E       = 8'h45;
  localparam logic [7:0] CH_MINUS   = 8'h2D;
  localparam logic [7:0] CH_FILL    = 8'h20;
  localparam logic [3:0] FC_TEN     = 4'hA;

endpackage

// File: core/vsp_scanner_port.sv
// Contract
// RQ1: Bit 15 set starts conversion after applying
// RQ2: Program word bits 14-8 are ignored
// RQ3: Bits 2-0 select measurement range
// RQ4: Bits 5-3 select measurement function
// RQ5: Bits 7-6 select sample period
// RQ6: Result is eight BCD digits, 32 bits
// RQ7: Reader scales data by ten to -range
// RQ8: Function digit uses fixed 8-4-2-1 codes
// RQ9: Characters: digits, exponent, fill, function code
// RQ10: Integer function code only for 8-4-2-1
// RQ11: Release command lifts hold-off for reading
// RQ12: Input command returns characters or BCD word
// RQ13: Host releases first, then writes program word
// RQ14: Scanner write encodes after settling delay
// RQ15: Host clears bit 15 when channel correct
// RQ16: Scanner accepts channel 0-999 and word
// RQ17: Scanner word low bits: two octal digits
// RQ18: Scanner function: volts, frequency, resistance
// RQ19: Delay digit selects settling time column
// RQ20: One reading per release, then hold off
`timescale 1ns/1ps
`default_nettype none

module vsp_scanner_port #(
  parameter int unsigned DLY_HV_CYC [8] =
    vsp_pkg::vsp_us_to_cyc(vsp_pkg::DLY_HV_US),
  parameter int unsigned DLY_NORM_CYC [8] =
    vsp_pkg::vsp_us_to_cyc(vsp_pkg::DLY_NORM_US)
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic        RELEASE_STB,
  input  wire logic        PROG_WR_STB,
  input  wire logic [15:0] PROG_WORD,
  input  wire logic        SCAN_WR_STB,
  input  wire logic [9:0]  SCAN_CHAN,
  input  wire logic [15:0] SCAN_WORD,
  input  wire logic        READ_STB,
  input  wire logic        READ_ASCII,
  input  wire logic        CHAR_ACK,
  input  wire logic        INST_DONE,
  input  wire logic [31:0] INST_BCD,
  input  wire logic        HV_SCANNER,
  output logic             VM_ENCODE,
  output logic [2:0]       VM_RANGE,
  output logic [2:0]       VM_FUNC,
  output logic [1:0]       VM_PERIOD,
  output logic             SC_LOAD,
  output logic [9:0]       SC_CHAN,
  output logic [2:0]       SC_FUNC,
  output logic [2:0]       SC_DELAY,
  output logic             HOLDOFF_RELEASED,
  output logic             BUSY,
  output logic             RESULT_VALID,
  output logic             RD_WORD_STB,
  output logic [31:0]      RD_WORD,
  output logic             CHAR_VALID,
  output logic [7:0]       CHAR_DATA
);

  for (genvar g = 0; g < 8; g++) begin : g_chk
    if (DLY_HV_CYC[g] == 0 || DLY_HV_CYC[g] >= (1 << vsp_pkg::DLY_CNT_W) ||
        DLY_NORM_CYC[g] == 0 ||
        DLY_NORM_CYC[g] >= (1 << vsp_pkg::DLY_CNT_W)) begin : g_bad
      $error("Settling delay count out of range");
    end
  end

  typedef enum logic [1:0] {
    VSP_ST_IDLE    = 2'h0,
    VSP_ST_SETTLE  = 2'h1,
    VSP_ST_ARMED   = 2'h2,
    VSP_ST_MEASURE = 2'h3
  } vsp_state_t;

  localparam int DW = vsp_pkg::DIGIT_W;
  localparam int CW = vsp_pkg::DLY_CNT_W;

  // Instrument pins come from another domain
  logic        done_s1_ff, done_s2_ff, done_s3_ff;
  logic [31:0] bcd_s1_ff,  bcd_s2_ff;
  logic        hv_s1_ff,   hv_s2_ff;
  logic        done_rise;

  vsp_state_t  state_ff,    nxt_state_ff;
  logic        released_ff, nxt_released_ff;
  logic        encode_ff,   nxt_encode_ff;
  logic [2:0]  range_ff,    nxt_range_ff;
  logic [2:0]  func_ff,     nxt_func_ff;
  logic [1:0]  period_ff,   nxt_period_ff;
  logic        scload_ff,   nxt_scload_ff;
  logic [9:0]  chan_ff,     nxt_chan_ff;
  logic [2:0]  scfunc_ff,   nxt_scfunc_ff;
  logic [2:0]  scdly_ff,    nxt_scdly_ff;
  logic [CW-1:0] dly_ff,    nxt_dly_ff;
  logic [31:0] result_ff,   nxt_result_ff;
  logic        rvalid_ff,   nxt_rvalid_ff;
  logic [31:0] rdword_ff,   nxt_rdword_ff;
  logic        rdstb_ff,    nxt_rdstb_ff;
  logic        cbusy_ff,    nxt_cbusy_ff;
  logic [3:0]  cidx_ff,     nxt_cidx_ff;
  logic [7:0]  char_ff,     nxt_char_ff;

  function automatic logic [7:0] digit_char(input logic [3:0] d);
    return vsp_pkg::CH_ZERO + {4'h0, d};
  endfunction

  // Integer form of the function digit is defined for 8-4-2-1 codes only
  function automatic logic is_8421(input logic [3:0] f);
    return f <= 4'h5 || f == vsp_pkg::VSP_RF_OVERLOAD ||
           f == vsp_pkg::VSP_RF_AC_VOLTS;                       // [RQ10] [RQ8]
  endfunction

  function automatic logic [7:0] char_of(input logic [3:0]  idx,
                                         input logic [31:0] res);
    logic [3:0]  rng;
    logic [3:0]  fn;
    logic [23:0] sh;
    rng = res[vsp_pkg::RES_RANGE_LSB +: DW];
    fn  = res[vsp_pkg::RES_FUNC_LSB +: DW];
    sh  = res[vsp_pkg::RES_DATA_W-1:0] >> {vsp_pkg::IDX_D1 - idx, 2'h0};
    if (idx == vsp_pkg::IDX_RANGE || idx == vsp_pkg::IDX_EXP_R) begin
      return digit_char(rng);                                   // [RQ9]
    end else if (idx == vsp_pkg::IDX_FUNC) begin
      return digit_char(fn);
    end else if (idx <= vsp_pkg::IDX_D1) begin
      return digit_char(sh[DW-1:0]);
    end else if (idx == vsp_pkg::IDX_EXP_E) begin
      return vsp_pkg::CH_E;
    end else if (idx == vsp_pkg::IDX_EXP_SG) begin
      return vsp_pkg::CH_MINUS;
    end else if (idx == vsp_pkg::IDX_EXP_Z) begin
      return vsp_pkg::CH_ZERO;
    end else if (idx < vsp_pkg::IDX_FC_HI || !is_8421(fn)) begin
      return vsp_pkg::CH_FILL;
    end else if (idx == vsp_pkg::IDX_FC_HI) begin
      return (fn >= vsp_pkg::FC_TEN) ? vsp_pkg::CH_ONE : vsp_pkg::CH_ZERO;
    end else begin
      return digit_char((fn >= vsp_pkg::FC_TEN) ? fn - vsp_pkg::FC_TEN : fn);
    end
  endfunction

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
      done_s3_ff <= 1'b0;
      bcd_s1_ff  <= 32'h0000_0000;
      bcd_s2_ff  <= 32'h0000_0000;
      hv_s1_ff   <= 1'b0;
      hv_s2_ff   <= 1'b0;
    end else if (CE) begin
      done_s1_ff <= INST_DONE;
      done_s2_ff <= done_s1_ff;
      done_s3_ff <= done_s2_ff;
      bcd_s1_ff  <= INST_BCD;
      bcd_s2_ff  <= bcd_s1_ff;
      hv_s1_ff   <= HV_SCANNER;
      hv_s2_ff   <= hv_s1_ff;
    end
  end

  // Data pins are settled long before done rises, so the word is coherent
  assign done_rise = done_s2_ff && !done_s3_ff;

  always_comb begin
    nxt_state_ff    = state_ff;
    nxt_released_ff = released_ff;
    nxt_encode_ff   = 1'b0;
    nxt_range_ff    = range_ff;
    nxt_func_ff     = func_ff;
    nxt_period_ff   = period_ff;
    nxt_scload_ff   = 1'b0;
    nxt_chan_ff     = chan_ff;
    nxt_scfunc_ff   = scfunc_ff;
    nxt_scdly_ff    = scdly_ff;
    nxt_dly_ff      = dly_ff;
    nxt_result_ff   = result_ff;
    nxt_rvalid_ff   = rvalid_ff;
    nxt_rdword_ff   = rdword_ff;
    nxt_rdstb_ff    = 1'b0;
    nxt_cbusy_ff    = cbusy_ff;
    nxt_cidx_ff     = cidx_ff;
    nxt_char_ff     = char_ff;

    // Settings always apply; bits 14-8 are never looked at
    if (PROG_WR_STB) begin
      nxt_range_ff  = PROG_WORD[vsp_pkg::PW_RANGE_LSB +: vsp_pkg::OCT_W];
      nxt_func_ff   = PROG_WORD[vsp_pkg::PW_FUNC_LSB +: vsp_pkg::OCT_W];
      nxt_period_ff = PROG_WORD[vsp_pkg::PW_PER_LSB +: vsp_pkg::PER_W];
    end                                              // [RQ2] [RQ3] [RQ4] [RQ5]

    unique case (state_ff)
      VSP_ST_IDLE: begin
        if (SCAN_WR_STB && SCAN_CHAN <= vsp_pkg::CHAN_MAX) begin
          nxt_chan_ff   = SCAN_CHAN;                               // [RQ16]
          nxt_scfunc_ff = SCAN_WORD[vsp_pkg::SW_FUNC_LSB +: vsp_pkg::OCT_W];
          nxt_scdly_ff  = SCAN_WORD[vsp_pkg::SW_DELAY_LSB +: vsp_pkg::OCT_W];
          nxt_scload_ff = 1'b1;                             // [RQ17] [RQ18]
          nxt_dly_ff    = hv_s2_ff ?
            CW'(DLY_HV_CYC[nxt_scdly_ff]) :
            CW'(DLY_NORM_CYC[nxt_scdly_ff]);                       // [RQ19]
          nxt_state_ff  = VSP_ST_SETTLE;
        end else if (PROG_WR_STB && PROG_WORD[vsp_pkg::PW_ENCODE_BIT]) begin
          nxt_state_ff  = VSP_ST_ARMED;                              // [RQ1]
        end
      end
      VSP_ST_SETTLE: begin
        nxt_dly_ff = dly_ff - CW'(1);
        if (dly_ff == CW'(1)) begin
          nxt_state_ff = VSP_ST_ARMED;                              // [RQ14]
        end
      end
      VSP_ST_ARMED: begin
        // Encode waits for the host's release
        if (released_ff) begin
          nxt_encode_ff = 1'b1;                             // [RQ11] [RQ13]
          nxt_state_ff  = VSP_ST_MEASURE;
        end
      end
      VSP_ST_MEASURE: begin
        if (done_rise) begin
          nxt_result_ff   = bcd_s2_ff;                               // [RQ6]
          nxt_rvalid_ff   = 1'b1;
          nxt_released_ff = 1'b0;                                   // [RQ20]
          nxt_state_ff    = VSP_ST_IDLE;
        end
      end
    endcase

    // Release after the clear so a coinciding release is not lost
    if (RELEASE_STB) begin
      nxt_released_ff = 1'b1;                                       // [RQ11]
    end

    if (cbusy_ff) begin
      if (CHAR_ACK) begin
        if (cidx_ff == vsp_pkg::IDX_LAST) begin
          nxt_cbusy_ff = 1'b0;
        end else begin
          nxt_cidx_ff = cidx_ff + 4'h1;
          nxt_char_ff = char_of(cidx_ff + 4'h1, result_ff);          // [RQ9]
        end
      end
    end else if (READ_STB && rvalid_ff) begin
      if (READ_ASCII) begin
        nxt_cbusy_ff = 1'b1;                                        // [RQ12]
        nxt_cidx_ff  = vsp_pkg::IDX_RANGE;
        nxt_char_ff  = char_of(vsp_pkg::IDX_RANGE, result_ff);
      end else begin
        nxt_rdword_ff = result_ff;                                  // [RQ12]
        nxt_rdstb_ff  = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_ff    <= VSP_ST_IDLE;
      released_ff <= 1'b0;
      encode_ff   <= 1'b0;
      range_ff    <= vsp_pkg::VSP_RNG_AUTO;
      func_ff     <= vsp_pkg::VSP_FN_AC_NORMAL;
      period_ff   <= vsp_pkg::VSP_PER_1S;
      scload_ff   <= 1'b0;
      chan_ff     <= 10'h000;
      scfunc_ff   <= vsp_pkg::VSP_SF_ACDC;
      scdly_ff    <= 3'h0;
      dly_ff      <= '0;
      result_ff   <= 32'h0000_0000;
      rvalid_ff   <= 1'b0;
      rdword_ff   <= 32'h0000_0000;
      rdstb_ff    <= 1'b0;
      cbusy_ff    <= 1'b0;
      cidx_ff     <= 4'h0;
      char_ff     <= 8'h00;
    end else if (CE) begin
      state_ff    <= nxt_state_ff;
      released_ff <= nxt_released_ff;
      encode_ff   <= nxt_encode_ff;
      range_ff    <= nxt_range_ff;
      func_ff     <= nxt_func_ff;
      period_ff   <= nxt_period_ff;
      scload_ff   <= nxt_scload_ff;
      chan_ff     <= nxt_chan_ff;
      scfunc_ff   <= nxt_scfunc_ff;
      scdly_ff    <= nxt_scdly_ff;
      dly_ff      <= nxt_dly_ff;
      result_ff   <= nxt_result_ff;
      rvalid_ff   <= nxt_rvalid_ff;
      rdword_ff   <= nxt_rdword_ff;
      rdstb_ff    <= nxt_rdstb_ff;
      cbusy_ff    <= nxt_cbusy_ff;
      cidx_ff     <= nxt_cidx_ff;
      char_ff     <= nxt_char_ff;
    end
  end

  assign VM_ENCODE        = encode_ff;
  assign VM_RANGE         = range_ff;
  assign VM_FUNC          = func_ff;
  assign VM_PERIOD        = period_ff;
  assign SC_LOAD          = scload_ff;
  assign SC_CHAN          = chan_ff;
  assign SC_FUNC          = scfunc_ff;
  assign SC_DELAY         = scdly_ff;
  assign HOLDOFF_RELEASED = released_ff;
  assign BUSY             = state_ff != VSP_ST_IDLE;
  assign RESULT_VALID     = rvalid_ff;
  assign RD_WORD_STB      = rdstb_ff;
  assign RD_WORD          = rdword_ff;
  assign CHAR_VALID       = cbusy_ff;
  assign CHAR_DATA        = char_ff;

  AST_ENCODE_ON_BIT15: assert property (@(posedge CLK) // [RQ1]
    disable iff (RESET || !CE)
    state_ff == VSP_ST_IDLE && PROG_WR_STB && !SCAN_WR_STB
    && PROG_WORD[vsp_pkg::PW_ENCODE_BIT] && released_ff |-> ##2 VM_ENCODE)
    else $error("Encode bit did not start a conversion");

  AST_NO_ENCODE_BIT15_LOW: assert property (@(posedge CLK) // [RQ1]
    disable iff (RESET || !CE)
    state_ff == VSP_ST_IDLE && PROG_WR_STB && !SCAN_WR_STB
    && !PROG_WORD[vsp_pkg::PW_ENCODE_BIT]
    |=> state_ff == VSP_ST_IDLE ##1 !VM_ENCODE)
    else $error("Conversion started without encode bit");

  AST_SETTINGS_HOLD: assert property (@(posedge CLK) // [RQ3]
    disable iff (RESET || !CE)
    !PROG_WR_STB |=> $stable(VM_RANGE) && $stable(VM_FUNC)
    && $stable(VM_PERIOD))
    else $error("Settings changed without a program write");

  AST_ENCODE_NEEDS_RELEASE: assert property (@(posedge CLK) // [RQ11]
    disable iff (RESET || !CE)
    $rose(VM_ENCODE) |-> $past(released_ff) && state_ff == VSP_ST_MEASURE)
    else $error("Encode issued while held off");

  AST_ONE_PER_RELEASE: assert property (@(posedge CLK) // [RQ20]
    disable iff (RESET || !CE)
    state_ff == VSP_ST_MEASURE && done_rise && !RELEASE_STB && !READ_STB
    |=> RESULT_VALID && !HOLDOFF_RELEASED && RD_WORD_STB == 1'b0
    ##0 state_ff == VSP_ST_IDLE)
    else $error("Hold-off not restored after a reading");

  AST_SCAN_CHAN_LIMIT: assert property (@(posedge CLK) // [RQ16]
    disable iff (RESET || !CE)
    SCAN_WR_STB && SCAN_CHAN > vsp_pkg::CHAN_MAX |=> !SC_LOAD)
    else $error("Channel above 999 accepted");

  AST_SCAN_FIELDS: assert property (@(posedge CLK) // [RQ17]
    disable iff (RESET || !CE)
    SC_LOAD |-> SC_FUNC == $past(SCAN_WORD[5:3])
    && SC_DELAY == $past(SCAN_WORD[2:0]) && state_ff == VSP_ST_SETTLE)
    else $error("Scanner digits taken from wrong bits");

  AST_SETTLE_THEN_ARM: assert property (@(posedge CLK) // [RQ14]
    disable iff (RESET || !CE)
    state_ff == VSP_ST_SETTLE && dly_ff == CW'(1)
    |=> state_ff == VSP_ST_ARMED)
    else $error("Settling end did not arm the conversion");

  AST_BCD_READ: assert property (@(posedge CLK) // [RQ12]
    disable iff (RESET || !CE)
    READ_STB && !READ_ASCII && RESULT_VALID && !CHAR_VALID
    |=> RD_WORD_STB && RD_WORD == $past(result_ff))
    else $error("BCD read returned wrong word");

  AST_CHAR_EXPONENT: assert property (@(posedge CLK) // [RQ9]
    disable iff (RESET || !CE)
    CHAR_VALID && cidx_ff == vsp_pkg::IDX_EXP_E |-> CHAR_DATA == vsp_pkg::CH_E)
    else $error("Exponent letter missing");

endmodule // vsp_scanner_port

`default_nettype wire

// File: sim/tb_vsp_scanner_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_vsp_scanner_port;
  localparam int unsigned SIM_HV [8] = '{30, 35, 44, 54, 84, 124, 290, 1000};
  localparam int unsigned SIM_NR [8] = '{44, 54, 44, 54, 290, 1000, 290, 1000};

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic        release_stb = 1'b0;
  logic        prog_wr_stb = 1'b0;
  logic [15:0] prog_word = 16'h0;
  logic        scan_wr_stb = 1'b0;
  logic [9:0]  scan_chan = 10'h0;
  logic [15:0] scan_word = 16'h0;
  logic        read_stb = 1'b0;
  logic        read_ascii = 1'b0;
  logic        char_ack = 1'b0;
  logic        hv_scanner = 1'b0;
  logic [31:0] model_val = 32'h0;
  logic        inst_done, vm_encode, sc_load, holdoff, busy, res_valid;
  logic        rd_word_stb, char_valid;
  logic [31:0] inst_bcd, rd_word;
  logic [2:0]  vm_range, vm_func, sc_func, sc_delay;
  logic [1:0]  vm_period;
  logic [9:0]  sc_chan;
  logic [7:0]  char_data;
  int          enc_count, miscompares = 0, cmp_count = 0, cycles = 0;

  always #50 clk = ~clk;

  vsp_scanner_port #(.DLY_HV_CYC(SIM_HV), .DLY_NORM_CYC(SIM_NR))
    u_vsp_scanner_port (
    .CLK(clk), .RESET(reset), .CE(ce), .RELEASE_STB(release_stb),
    .PROG_WR_STB(prog_wr_stb), .PROG_WORD(prog_word),
    .SCAN_WR_STB(scan_wr_stb), .SCAN_CHAN(scan_chan),
    .SCAN_WORD(scan_word), .READ_STB(read_stb), .READ_ASCII(read_ascii),
    .CHAR_ACK(char_ack), .INST_DONE(inst_done), .INST_BCD(inst_bcd),
    .HV_SCANNER(hv_scanner), .VM_ENCODE(vm_encode), .VM_RANGE(vm_range),
    .VM_FUNC(vm_func), .VM_PERIOD(vm_period), .SC_LOAD(sc_load),
    .SC_CHAN(sc_chan), .SC_FUNC(sc_func), .SC_DELAY(sc_delay),
    .HOLDOFF_RELEASED(holdoff), .BUSY(busy), .RESULT_VALID(res_valid),
    .RD_WORD_STB(rd_word_stb), .RD_WORD(rd_word),
    .CHAR_VALID(char_valid), .CHAR_DATA(char_data));

  vsp_inst_model u_vsp_inst_model (
    .clk(clk), .reset(reset), .encode(vm_encode), .value(model_val),
    .done(inst_done), .bcd(inst_bcd), .enc_count(enc_count));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic strobe_prog(input logic [15:0] w);
    @(negedge clk) prog_word = w;
    prog_wr_stb = 1'b1;
    @(negedge clk) prog_wr_stb = 1'b0;
  endtask

  task automatic strobe_release;
    @(negedge clk) release_stb = 1'b1;
    @(negedge clk) release_stb = 1'b0;
  endtask

  task automatic strobe_scan(input logic [9:0] ch, input logic [15:0] w);
    @(negedge clk) scan_chan = ch;
    scan_word = w;
    scan_wr_stb = 1'b1;
    @(negedge clk) scan_wr_stb = 1'b0;
  endtask

  // Counts falling edges since the launching write, one already passed
  task automatic wait_enc(output int n);
    n = 1;
    while (vm_encode !== 1'b1 && n < 1100) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_idle;
    for (int t = 0; t < 60 && busy !== 1'b0; t++) @(negedge clk);
    chk_val(busy, 0, "still busy");
  endtask

  function automatic logic [7:0] exp_char(input logic [31:0] v, input int k);
    logic [3:0] f;
    f = v[27:24];
    if (k < 8) return 8'h30 + {4'h0, v[31-4*k -: 4]};
    case (k)
      8: return 8'h45;
      9: return 8'h2D;
      10: return 8'h30;
      11: return 8'h30 + {4'h0, v[31:28]};
      14: return (f <= 4'h5 || f == 4'h9) ? 8'h30 :
                 (f == 4'hB) ? 8'h31 : 8'h20;
      15: return (f <= 4'h5 || f == 4'h9) ? 8'h30 + {4'h0, f} :
                 (f == 4'hB) ? 8'h31 : 8'h20;
      default: return 8'h20;
    endcase
  endfunction

  task automatic read_back(input logic [31:0] v);
    int t;
    @(negedge clk) read_stb = 1'b1;
    read_ascii = 1'b0;
    @(negedge clk) read_stb = 1'b0;
    chk_val(rd_word_stb, 1, "word strobe");
    chk_val(rd_word, v, "bcd word");
    @(negedge clk) read_stb = 1'b1;
    read_ascii = 1'b1;
    @(negedge clk) read_stb = 1'b0;
    for (int k = 0; k < 16; k++) begin
      for (t = 0; t < 20 && char_valid !== 1'b1; t++) @(negedge clk);
      chk_val(char_data, exp_char(v, k), "character");
      char_ack = 1'b1;
      @(negedge clk) char_ack = 1'b0;
    end
    chk_val(char_valid, 0, "stream end");
  endtask

  task automatic t_settings;
    int base;
    base = enc_count;
    strobe_release();
    for (int i = 0; i < 8; i++) begin
      // Upper byte junk must not reach the settings
      strobe_prog({1'b0, 7'h55, 2'(i % 3), 3'(i % 6), 3'(i)});
      chk_val(vm_range, i, "range");
      chk_val(vm_func, i % 6, "function");
      chk_val(vm_period, i % 3, "period");
    end
    // A write while the clock enable is low must leave the settings alone
    @(negedge clk) ce = 1'b0;
    strobe_prog(16'h0000);
    chk_val(vm_range, 7, "clock enable freeze");
    @(negedge clk) ce = 1'b1;
    repeat (4) @(negedge clk);
    chk_val(enc_count, base, "encode without bit 15");
    $display("test settings done");
  endtask

  task automatic t_encode;
    logic [31:0] vals [4] = '{32'h41163525, 32'h3B001234,
                              32'h29099999, 32'h06000042};
    int n;
    int base;
    for (int i = 0; i < 4; i++) begin
      base = enc_count;
      model_val = vals[i];
      strobe_release();
      strobe_prog(16'hFF24);
      chk_val(vm_range, 4, "range");
      wait_enc(n);
      chk_val(n, 2, "encode latency");
      wait_idle();
      chk_val({res_valid, holdoff}, 2'b10, "result state");
      chk_val(enc_count, base + 1, "one reading");
      read_back(vals[i]);
    end
    $display("test encode done");
  endtask

  task automatic t_holdoff;
    int n;
    int base;
    base = enc_count;
    model_val = 32'h51000007;
    strobe_prog(16'h8024);
    repeat (10) @(negedge clk);
    chk_val(enc_count, base, "encode while held off");
    strobe_release();
    wait_enc(n);
    chk_val(n, 2, "encode after release");
    wait_idle();
    read_back(32'h51000007);
    $display("test holdoff done");
  endtask

  task automatic t_scan;
    int n;
    int d;
    logic [9:0] ch;
    for (int hv = 0; hv < 2; hv++) begin
      hv_scanner = hv[0];
      for (d = 0; d < 8; d++) begin
        ch = 10'(999 - d * 111);
        strobe_release();
        strobe_prog(16'h0024);
        strobe_scan(ch, {10'h0, 3'(d % 3), 3'(d)});
        chk_val(sc_load, 1, "scanner load");
        chk_val(sc_chan, ch, "channel");
        chk_val({sc_func, sc_delay}, {3'(d % 3), 3'(d)}, "digits");
        wait_enc(n);
        chk_val(n, (hv ? SIM_HV[d] : SIM_NR[d]) + 2, "settling");
        wait_idle();
      end
    end
    strobe_scan(10'h3E8, 16'h0000);
    chk_val({sc_load, busy}, 2'b00, "channel above range");
    $display("test scan done");
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("[FAIL] %0t run did not finish", $time);
      wrap_up();
    end
  end

  initial begin
    repeat (9) @(negedge clk);
    chk_val({vm_range, vm_func, vm_period, vm_encode, sc_load, holdoff,
             busy, res_valid, char_valid}, 0, "reset outputs");
    @(negedge clk) reset = 1'b0;
    $display("test reset done");
    t_settings();
    t_encode();
    t_holdoff();
    t_scan();
    wrap_up();
  end
endmodule // tb_vsp_scanner_port

`default_nettype wire

// File: sim/vsp_inst_model.sv
`timescale 1ns/1ps
`default_nettype none

module vsp_inst_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        encode,
  input  wire logic [31:0] value,
  output logic             done,
  output logic [31:0]      bcd,
  output int               enc_count
);
  int step;

  // Digits stand from before done rises to well after; once that window ends
  // they are inverted so a late capture cannot pass by luck
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      step <= 0;
      done <= 1'b0;
      bcd <= 32'h0;
      enc_count <= 0;
    end else if (encode) begin
      step <= 1;
      enc_count <= enc_count + 1;
    end else if (step != 0) begin
      step <= (step == 14) ? 0 : step + 1;
      if (step == 4) bcd <= value;
      if (step == 5) done <= 1'b1;
      if (step == 11) done <= 1'b0;
      if (step == 14) bcd <= ~value;
    end
  end
endmodule // vsp_inst_model

`default_nettype wire
